/* File: logic/rx_tuning_regs.sv */
// receiver tuning register bank behind the serial register port
`include "rx_tuning_defines.svh"

module rx_tuning_regs
	import rx_tuning_pkg::*;
(
	// clock and reset
	input  wire logic     clk,
	input  wire logic     rst_n,
	// serial register port pins
	input  wire logic     sclk,
	input  wire logic     mosi,
	input  wire logic     nss_n,
	output logic          miso,
	output logic          misoOe,
	// low-beta correction enable from the afc block
	input  wire logic     narrowModCorrectionEnable,
	// decoded tuning to the analog and dsp blocks
	output tuning_s       tuning
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] sclkSync_reg;
	logic [1:0] mosiSync_reg;
	logic [1:0] nssSync_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclkSync_reg <= 3'h0;
			mosiSync_reg <= 2'h0;
			nssSync_reg  <= 2'h3;
		end else begin
			sclkSync_reg <= {sclkSync_reg[1:0], sclk};
			mosiSync_reg <= {mosiSync_reg[0], mosi};
			nssSync_reg  <= {nssSync_reg[0], nss_n};
		end
	end

	wire sclkRise = sclkSync_reg[1] & ~sclkSync_reg[2];
	wire sclkFall = ~sclkSync_reg[1] & sclkSync_reg[2];
	wire selected = ~nssSync_reg[1];
	wire mosiBit  = mosiSync_reg[1];

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] lnaGainBoostCode_reg;
	logic [7:0] refSelect_reg;
	logic [7:0] loopBw_reg;
	logic [7:0] fadingMarginCode_reg;
	logic [7:0] narrowModFreqOffset_reg;

	// ----------------------------------------------------------------
	// serial frame state
	// ----------------------------------------------------------------
	spi_state_e state_reg;
	spi_state_e state_next;
	logic [7:0] shift_reg;
	logic [2:0] bitCnt_reg;
	logic [6:0] addr_reg;
	logic       writeOp_reg;
	logic [7:0] tx_reg;
	logic       txFresh_reg;
	logic       misoOe_reg;

	wire [7:0] byteIn   = {shift_reg[6:0], mosiBit};
	wire       byteDone = sclkRise && (bitCnt_reg == 3'h7);
	wire       addrDone = byteDone && (state_reg == SPI_ADDR);
	wire       dataDone = byteDone && (state_reg == SPI_DATA);
	wire       doWrite  = dataDone && writeOp_reg;
	wire [6:0] frameAddr = addrDone ? byteIn[6:0] : addr_reg;
	// burst access walks upward after each data byte
	wire [6:0] readAddr  = dataDone ? 7'(addr_reg + 7'h1) : frameAddr;

	// ----------------------------------------------------------------
	// read decode; unmapped offsets read as zero
	// ----------------------------------------------------------------
	wire hitLna    = (readAddr == `OFS_LNA_TUNE);
	wire hitRef    = (readAddr == `OFS_REF_SELECT);
	wire hitBw     = (readAddr == `OFS_LOOP_BW);
	wire hitMargin = (readAddr == `OFS_AGC_MARGIN);
	wire hitAfc    = (readAddr == `OFS_AFC_OFFSET);
	wire [7:0] readData = ({8{hitLna}}    & lnaGainBoostCode_reg)
	                    | ({8{hitRef}}    & refSelect_reg)
	                    | ({8{hitBw}}     & loopBw_reg)
	                    | ({8{hitMargin}} & fadingMarginCode_reg)
	                    | ({8{hitAfc}}    & narrowModFreqOffset_reg);

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	wire wrLna    = doWrite && (addr_reg == `OFS_LNA_TUNE);
	wire wrRef    = doWrite && (addr_reg == `OFS_REF_SELECT);
	wire wrBw     = doWrite && (addr_reg == `OFS_LOOP_BW);
	wire wrMargin = doWrite && (addr_reg == `OFS_AGC_MARGIN);
	wire wrAfc    = doWrite && (addr_reg == `OFS_AFC_OFFSET);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			SPI_IDLE: begin
				if (selected) begin
					state_next = SPI_ADDR;
				end
			end
			SPI_ADDR: begin
				if (addrDone) begin
					state_next = SPI_DATA;
				end
			end
			SPI_DATA: begin
				state_next = SPI_DATA;
			end
		endcase
		// deselect aborts any partial byte
		if (!selected) begin
			state_next = SPI_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg   <= SPI_IDLE;
			shift_reg   <= 8'h00;
			bitCnt_reg  <= 3'h0;
			addr_reg    <= 7'h00;
			writeOp_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (!selected) begin
				bitCnt_reg <= 3'h0;
			end else if (sclkRise) begin
				shift_reg  <= byteIn;
				bitCnt_reg <= 3'(bitCnt_reg + 3'h1);
			end
			if (addrDone) begin
				writeOp_reg <= byteIn[`SPI_WRITE_BIT];
			end
			if (addrDone || dataDone) begin
				addr_reg <= readAddr;
			end
		end
	end

	// ----------------------------------------------------------------
	// read data out, msb first; the loaded bit must survive one fall
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_reg      <= 8'h00;
			txFresh_reg <= 1'b0;
			misoOe_reg  <= 1'b0;
		end else begin
			misoOe_reg <= selected;
			if (addrDone || dataDone) begin
				tx_reg      <= readData;
				txFresh_reg <= 1'b1;
			end else if (sclkFall) begin
				if (txFresh_reg) begin
					txFresh_reg <= 1'b0;
				end else begin
					tx_reg <= {tx_reg[6:0], 1'b0};
				end
			end
		end
	end

	assign miso   = tx_reg[7];
	assign misoOe = misoOe_reg;

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lnaGainBoostCode_reg    <= `RST_LNA_TUNE;
			refSelect_reg           <= `RST_REF_SELECT;
			loopBw_reg              <= `RST_LOOP_BW;
			fadingMarginCode_reg    <= `RST_AGC_MARGIN;
			narrowModFreqOffset_reg <= `RST_AFC_OFFSET;
		end else begin
			if (wrLna) begin
				lnaGainBoostCode_reg <= byteIn;
			end
			if (wrRef) begin
				refSelect_reg <= byteIn;
			end
			if (wrBw) begin
				loopBw_reg <= byteIn;
			end
			if (wrMargin) begin
				fadingMarginCode_reg <= byteIn;
			end
			if (wrAfc) begin
				narrowModFreqOffset_reg <= byteIn;
			end
		end
	end

	// ----------------------------------------------------------------
	// decoded tuning
	// ----------------------------------------------------------------
	wire [1:0] loopBwCode = loopBw_reg[`LOOP_BW_HI:`LOOP_BW_LO];
	wire [9:0] loopBwKhz  = (loopBwCode == 2'h0) ? `LOOP_BW_KHZ0 :
	                        (loopBwCode == 2'h1) ? `LOOP_BW_KHZ1 :
	                        (loopBwCode == 2'h2) ? `LOOP_BW_KHZ2 :
	                                               `LOOP_BW_KHZ3;

	wire margin0 = (fadingMarginCode_reg == `MARGIN_NORMAL);
	wire margin2 = (fadingMarginCode_reg == `MARGIN_LOWBETA);
	wire margin3 = (fadingMarginCode_reg == `MARGIN_NOLOWBETA);
	margin_mode_e marginMode;
	assign marginMode = margin0 ? MARGIN_NORMAL :
	                    margin2 ? MARGIN_LOWBETA :
	                    margin3 ? MARGIN_NOLOWBETA : MARGIN_OTHER;

	// offset is two's complement so correction can go either way
	wire signed [16:0] afcExt  = $signed({{9{narrowModFreqOffset_reg[7]}},
	                                      narrowModFreqOffset_reg});
	wire signed [16:0] afcProd = afcExt * `AFC_STEP_HZ;
	wire signed [16:0] afcApplied = narrowModCorrectionEnable ? afcProd : 17'sh00000;

	tuning_s tuning_next;
	tuning_s tuning_reg;
	assign tuning_next.lnaHighSens       = (lnaGainBoostCode_reg == `LNA_HIGH_SENS);
	assign tuning_next.externalRefSelect = refSelect_reg[`EXT_REF_BIT];
	assign tuning_next.loopBwKhz         = loopBwKhz;
	assign tuning_next.fadingMarginMode  = marginMode;
	assign tuning_next.afcOffsetHz       = afcApplied;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tuning_reg <= '0;
		end else begin
			tuning_reg <= tuning_next;
		end
	end

	assign tuning = tuning_reg;

endmodule

/* File: logic/rx_tuning_defines.svh */
// register offsets, reset values and field constants for the receiver tuning bank
`ifndef RX_TUNING_DEFINES_SVH
`define RX_TUNING_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_LNA_TUNE      7'h58
`define OFS_REF_SELECT    7'h59
`define OFS_LOOP_BW       7'h5f
`define OFS_AGC_MARGIN    7'h6f
`define OFS_AFC_OFFSET    7'h71

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_LNA_TUNE      8'h1b
`define RST_REF_SELECT    8'h09
`define RST_LOOP_BW       8'h08
`define RST_AGC_MARGIN    8'h30
`define RST_AFC_OFFSET    8'h00

// ----------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------
`define LNA_NORMAL        8'h1b
`define LNA_HIGH_SENS     8'h2d
`define EXT_REF_BIT       4
`define LOOP_BW_HI        3
`define LOOP_BW_LO        2
`define MARGIN_NORMAL     8'h00
`define MARGIN_LOWBETA    8'h20
`define MARGIN_NOLOWBETA  8'h30
`define LOOP_BW_KHZ0      10'h04b
`define LOOP_BW_KHZ1      10'h096
`define LOOP_BW_KHZ2      10'h12c
`define LOOP_BW_KHZ3      10'h258
`define AFC_STEP_HZ       17'sh001e8
`define SPI_WRITE_BIT     7

`endif

/* File: logic/rx_tuning_pkg.sv */
// types shared by the receiver tuning bank
package rx_tuning_pkg;

	typedef enum logic [2:0] {
		SPI_IDLE = 3'h1,
		SPI_ADDR = 3'h2,
		SPI_DATA = 3'h4
	} spi_state_e;

	typedef enum logic [1:0] {
		MARGIN_NORMAL    = 2'h0,
		MARGIN_LOWBETA   = 2'h1,
		MARGIN_NOLOWBETA = 2'h2,
		MARGIN_OTHER     = 2'h3
	} margin_mode_e;

	typedef struct packed {
		logic               lnaHighSens;
		logic               externalRefSelect;
		logic        [9:0]  loopBwKhz;
		margin_mode_e       fadingMarginMode;
		logic signed [16:0] afcOffsetHz;
	} tuning_s;

endpackage

/* File: bench/rx_tuning_regs_sva.sv */
// port assertions for the receiver tuning bank
`include "rx_tuning_defines.svh"

module rx_tuning_regs_sva
	import rx_tuning_pkg::*;
(
	input wire logic    clk,
	input wire logic    rst_n,
	input wire logic    sclk,
	input wire logic    mosi,
	input wire logic    nss_n,
	input wire logic    miso,
	input wire logic    misoOe,
	input wire logic    narrowModCorrectionEnable,
	input wire tuning_s tuning
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_afc_gated: assert property (
		!narrowModCorrectionEnable |=> tuning.afcOffsetHz == 17'sh00000)
		else $error("afc offset present while correction off");
	chk_afc_step: assert property (tuning.afcOffsetHz % `AFC_STEP_HZ == 17'sh00000)
		else $error("afc offset not a whole step");
	chk_bw_legal: assert property ($past(rst_n) |-> tuning.loopBwKhz inside
		{`LOOP_BW_KHZ0, `LOOP_BW_KHZ1, `LOOP_BW_KHZ2, `LOOP_BW_KHZ3})
		else $error("loop bandwidth off the table");
	chk_reset_dflt: assert property ($rose(rst_n) |=> !tuning.lnaHighSens
		&& tuning.loopBwKhz == `LOOP_BW_KHZ2)
		else $error("tuning defaults wrong after reset");
	chk_margin_dflt: assert property (
		rst_n && !$past(rst_n) ##1 1'b1 |-> tuning.fadingMarginMode == MARGIN_NOLOWBETA)
		else $error("margin default wrong after reset");
	chk_ref_hold: assert property (nss_n [*5] |=> $stable(tuning.externalRefSelect))
		else $error("reference select moved outside a frame");

	cover property (tuning.lnaHighSens);
	cover property (tuning.externalRefSelect);
	cover property (tuning.afcOffsetHz < 17'sh00000);
endmodule

bind rx_tuning_regs rx_tuning_regs_sva u_chk (
	.clk(clk), .rst_n(rst_n), .sclk(sclk), .mosi(mosi), .nss_n(nss_n), .miso(miso),
	.misoOe(misoOe), .narrowModCorrectionEnable(narrowModCorrectionEnable), .tuning(tuning));

/* File: bench/receiver_test_tuning_regs_bench.sv */
// self-checking bench for the receiver tuning bank
`include "rx_tuning_defines.svh"

module receiver_test_tuning_regs_bench
	import rx_tuning_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	logic         sclk = 1'b0;
	logic         mosi = 1'b0;
	logic         nss_n = 1'b1;
	logic         corrEn = 1'b0;
	logic         miso;
	logic         misoOe;
	tuning_s      tuning;
	logic [7:0]   q;
	int           err_total = 0;
	int           n_tests = 0;
	int           cyc = 0;
	logic [6:0]   ofsTab [5] = '{`OFS_LNA_TUNE, `OFS_REF_SELECT, `OFS_LOOP_BW,
		`OFS_AGC_MARGIN, `OFS_AFC_OFFSET};
	logic [7:0]   rstTab [5] = '{8'h1b, 8'h09, 8'h08, 8'h30, 8'h00};
	logic [9:0]   bwTab [4] = '{`LOOP_BW_KHZ0, `LOOP_BW_KHZ1, `LOOP_BW_KHZ2, `LOOP_BW_KHZ3};
	logic [7:0]   mTab [4] = '{`MARGIN_NORMAL, `MARGIN_LOWBETA, `MARGIN_NOLOWBETA, 8'h10};
	margin_mode_e modeTab [4] = '{MARGIN_NORMAL, MARGIN_LOWBETA, MARGIN_NOLOWBETA, MARGIN_OTHER};

	always #12.5 clk = ~clk;

	rx_tuning_regs u_dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .mosi(mosi), .nss_n(nss_n),
		.miso(miso), .misoOe(misoOe), .narrowModCorrectionEnable(corrEn), .tuning(tuning));

	// ----------------------------------------------------------------
	// serial port helpers
	// ----------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	// four clk per sclk phase keeps the host above the synchroniser minimum
	task automatic xb(input logic [7:0] t);
		for (int i = 7; i >= 0; i--) begin
			mosi = t[i];
			tick(4);
			q[i] = miso;
			sclk = 1'b1;
			tick(4);
			sclk = 1'b0;
		end
	endtask
	task automatic acc(input logic [7:0] a, input logic [7:0] d);
		nss_n = 1'b0;
		tick(4);
		xb(a);
		xb(d);
		tick(4);
		nss_n = 1'b1;
		tick(6);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		acc({1'b1, a}, d);
	endtask
	task automatic rd(input logic [6:0] a);
		acc({1'b0, a}, 8'h00);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		chk("loop bw khz", tuning.loopBwKhz, `LOOP_BW_KHZ2);
		chk("afc hz", tuning.afcOffsetHz, 17'sh00000);
		for (int i = 0; i < 5; i++) begin
			rd(ofsTab[i]);
			chk("reset value", q, rstTab[i]);
		end
		$display("t_reset done");
	endtask
	task automatic t_lna;
		wr(`OFS_LNA_TUNE, `LNA_HIGH_SENS);
		chk("high sens", tuning.lnaHighSens, 1'b1);
		rd(`OFS_LNA_TUNE);
		chk("lna read", q, `LNA_HIGH_SENS);
		wr(`OFS_LNA_TUNE, `LNA_NORMAL);
		chk("normal sens", tuning.lnaHighSens, 1'b0);
		$display("t_lna done");
	endtask
	task automatic t_ref;
		wr(`OFS_REF_SELECT, 8'h19);
		chk("ext ref", tuning.externalRefSelect, 1'b1);
		wr(`OFS_REF_SELECT, 8'hef);
		chk("crystal", tuning.externalRefSelect, 1'b0);
		$display("t_ref done");
	endtask
	task automatic t_bw;
		for (int c = 0; c < 4; c++) begin
			wr(`OFS_LOOP_BW, {4'h0, 2'(c), 2'h0});
			chk("loop bw khz", tuning.loopBwKhz, bwTab[c]);
		end
		$display("t_bw done");
	endtask
	task automatic t_agc;
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_AGC_MARGIN, mTab[i]);
			chk("margin mode", tuning.fadingMarginMode, modeTab[i]);
		end
		$display("t_agc done");
	endtask
	task automatic t_afc;
		wr(`OFS_AFC_OFFSET, 8'h05);
		chk("afc gated", tuning.afcOffsetHz, 17'sh00000);
		corrEn = 1'b1;
		tick(2);
		chk("afc hz", tuning.afcOffsetHz, 17'sh00005 * `AFC_STEP_HZ);
		wr(`OFS_AFC_OFFSET, 8'hff);
		chk("afc neg", tuning.afcOffsetHz, 17'sh1ffff * `AFC_STEP_HZ);
		corrEn = 1'b0;
		tick(2);
		chk("afc off", tuning.afcOffsetHz, 17'sh00000);
		$display("t_afc done");
	endtask
	// burst walks 0x58, 0x59 and then an unmapped offset that reads zero
	task automatic t_burst;
		nss_n = 1'b0;
		tick(4);
		chk("miso enable on", misoOe, 1'b1);
		xb({1'b1, `OFS_LNA_TUNE});
		xb(`LNA_HIGH_SENS);
		xb(8'h19);
		tick(4);
		nss_n = 1'b1;
		tick(6);
		chk("miso enable off", misoOe, 1'b0);
		chk("burst high sens", tuning.lnaHighSens, 1'b1);
		chk("burst ext ref", tuning.externalRefSelect, 1'b1);
		nss_n = 1'b0;
		tick(4);
		xb({1'b0, `OFS_LNA_TUNE});
		xb(8'h00);
		chk("burst lna read", q, `LNA_HIGH_SENS);
		xb(8'h00);
		chk("burst ref read", q, 8'h19);
		xb(8'h00);
		chk("unmapped read", q, 8'h00);
		tick(4);
		nss_n = 1'b1;
		tick(6);
		$display("t_burst done");
	endtask
	// reset in mid-run must bring the lna, ref, loop bw and margin registers back to their defaults
	task automatic t_rerst;
		rst_n = 1'b0;
		tick(8);
		rst_n = 1'b1;
		tick(4);
		chk("rerst loop bw khz", tuning.loopBwKhz, `LOOP_BW_KHZ2);
		chk("rerst ext ref", tuning.externalRefSelect, 1'b0);
		chk("rerst high sens", tuning.lnaHighSens, 1'b0);
		chk("rerst margin", tuning.fadingMarginMode, MARGIN_NOLOWBETA);
		rd(`OFS_LNA_TUNE);
		chk("rerst lna read", q, `LNA_NORMAL);
		$display("t_rerst done");
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// the whole run needs about 3500 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 12000) begin
			err_total++;
			final_report();
		end
	end

	initial begin
		tick(8);
		rst_n = 1'b1;
		tick(4);
		t_reset();
		t_lna();
		t_ref();
		t_bw();
		t_agc();
		t_afc();
		t_burst();
		t_rerst();
		final_report();
	end
endmodule
